// ---- hdl/mph_pkg.sv ----
// Purpose: Shared constants and types for the memory port request handshake.
// Assumes: One port, 32-bit half buses paired into 64-bit queue words.
// Notes:   Both ends and the queue module import this package whole.
package mph_pkg;

  localparam int WORD_W     = 32;
  localparam int PAIR_W     = 64;
  localparam int ADDR_W     = 32;
  localparam int IDX_W      = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int LVL_W      = 6;

  // Transfer length codes carried with each request.
  typedef enum logic [1:0] {
    LEN_SINGLE  = 2'h0,
    LEN_LINE4   = 2'h1,
    LEN_LINE8   = 2'h2,
    LEN_BURST32 = 2'h3
  } mph_len_t;

  localparam logic DIR_READ  = 1'h1;
  localparam logic DIR_WRITE = 1'h0;

  // Word index values after reset or completion, and the step per pop.
  localparam logic [IDX_W-1:0] IDX_RISE_RST = 5'h00;
  localparam logic [IDX_W-1:0] IDX_FALL_RST = 5'h01;
  localparam logic [IDX_W-1:0] IDX_STEP     = 5'h02;

  // Write queue level at which the full warnings rise.
  localparam logic [LVL_W-1:0] WQ_WARN_LVL = 6'h1f;

  // Most operations acknowledged and not yet finished in memory.
  localparam logic [2:0] OUTSTANDING_MAX = 3'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              read;
    mph_len_t          len;
  } mph_cmd_t;

  // Number of rise/fall word pairs that one operation moves.
  function automatic logic [4:0] mph_pairs(input mph_len_t len);
    unique case (len)
      LEN_SINGLE:  mph_pairs = 5'h01;
      LEN_LINE4:   mph_pairs = 5'h02;
      LEN_LINE8:   mph_pairs = 5'h04;
      LEN_BURST32: mph_pairs = 5'h10;
    endcase
  endfunction

endpackage

// ---- hdl/mph_link_if.sv ----
// Purpose: Port signals between the peripheral and the controller port.
// Assumes: Both ends run on the same clock, supplied to each module directly.
// Notes:   No clocking block; the bench joins the two ends through this.
`timescale 1ns/1ps
interface mph_link_if;
  import mph_pkg::*;

  // Request path.
  logic              port_request;
  logic              port_request_grant;
  logic [ADDR_W-1:0] port_target_location;
  logic              port_direction_is_read;
  mph_len_t          port_transfer_length_code;
  // Read path.
  logic              read_words_available;
  logic              read_pop_rise;
  logic              read_pop_fall;
  logic [WORD_W-1:0] read_bus_rise;
  logic [WORD_W-1:0] read_bus_fall;
  logic [IDX_W-1:0]  read_word_index_rise;
  logic [IDX_W-1:0]  read_word_index_fall;
  logic              read_done_pulse;
  logic              read_queue_flush;
  logic              read_channel_active;
  // Write path.
  logic              write_push_rise;
  logic              write_push_fall;
  logic [WORD_W-1:0] write_bus_rise;
  logic [WORD_W-1:0] write_bus_fall;
  logic              write_done_pulse;
  logic              write_queue_flush;
  logic              write_channel_active;
  logic              write_queue_full_rise;
  logic              write_queue_full_fall;

  modport dev (
    input  port_request, port_target_location, port_direction_is_read,
    input  port_transfer_length_code, read_pop_rise, read_pop_fall,
    input  read_done_pulse, read_queue_flush, write_push_rise,
    input  write_push_fall, write_bus_rise, write_bus_fall,
    input  write_done_pulse, write_queue_flush,
    output port_request_grant, read_words_available, read_bus_rise,
    output read_bus_fall, read_word_index_rise, read_word_index_fall,
    output read_channel_active, write_channel_active,
    output write_queue_full_rise, write_queue_full_fall
  );

  modport per (
    output port_request, port_target_location, port_direction_is_read,
    output port_transfer_length_code, read_pop_rise, read_pop_fall,
    output read_done_pulse, read_queue_flush, write_push_rise,
    output write_push_fall, write_bus_rise, write_bus_fall,
    output write_done_pulse, write_queue_flush,
    input  port_request_grant, read_words_available, read_bus_rise,
    input  read_bus_fall, read_word_index_rise, read_word_index_fall,
    input  read_channel_active, write_channel_active,
    input  write_queue_full_rise, write_queue_full_fall
  );

endinterface

// ---- hdl/mph_fifo.sv ----
// Purpose: Synchronous queue with valid/ready on both sides and a flush.
// Assumes: DEPTH is a power of two; pointers wrap naturally.
// Notes:   Output data is the head entry, read straight from the array.
`timescale 1ns/1ps
module mph_fifo
  import mph_pkg::*;
#(
  parameter int WIDTH = PAIR_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     flush,
  // Fill side.
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side.
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Occupancy.
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   count;
  } mph_fifo_st_t;

  mph_fifo_st_t     st_reg;
  mph_fifo_st_t     st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Full and empty come straight from the stored count.
  assign in_ready  = st_reg.count != (AW+1)'(DEPTH);
  assign out_valid = st_reg.count != '0;
  assign out_data  = mem[st_reg.rptr];
  assign level     = st_reg.count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update; a flush empties the queue at once.
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.wptr = st_reg.wptr + AW'(1);
    end
    if (pop)
    begin
      st_next.rptr = st_reg.rptr + AW'(1);
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Storage has no reset; stale words are never shown as valid.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[st_reg.wptr] <= in_data;
    end
  end

endmodule

// ---- hdl/mph_dev.sv ----
// Purpose: Controller end of one memory port: request queue, read and
//          write queues, busy flags and word indices.
// Assumes: The sequencer takes commands in order and marks the last word
//          pair of each operation on both data paths.
// Notes:
`timescale 1ns/1ps
module mph_dev
  import mph_pkg::*;
(
  // Clock and reset.
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  // Peripheral port.
  mph_link_if.dev                LINK,
  // Command path to the memory sequencer.
  output logic                   MEM_CMD_VALID,
  input  wire logic              MEM_CMD_READY,
  output logic [ADDR_W-1:0]      MEM_CMD_ADDR,
  output logic                   MEM_CMD_READ,
  output mph_len_t               MEM_CMD_LEN,
  // Read data from the sequencer.
  input  wire logic              MEM_RD_VALID,
  output logic                   MEM_RD_READY,
  input  wire logic [PAIR_W-1:0] MEM_RD_DATA,
  input  wire logic              MEM_RD_LAST,
  // Write data to the sequencer.
  output logic                   MEM_WR_VALID,
  input  wire logic              MEM_WR_READY,
  output logic [PAIR_W-1:0]      MEM_WR_DATA,
  input  wire logic              MEM_WR_LAST
);

  typedef struct packed {
    mph_cmd_t          cmd0;
    mph_cmd_t          cmd1;
    logic [1:0]        cmd_cnt;
    logic              grant;
    logic [1:0]        rd_cnt;
    logic [1:0]        wr_cnt;
    logic              rd_mid;
    logic              rdy;
    logic [IDX_W-1:0]  idx_rise;
    logic [IDX_W-1:0]  idx_fall;
    logic [WORD_W-1:0] rise_hold;
  } mph_dev_st_t;

  mph_dev_st_t       st_reg;
  mph_dev_st_t       st_next;
  mph_cmd_t          new_cmd;
  logic [2:0]        outstanding;
  logic              take;
  logic              pop_cmd;
  logic              rq_fire;
  logic              wq_fire;
  logic              rd_ld_last;
  logic              wr_st_last;
  logic              rq_out_valid;
  logic              wq_in_ready;
  logic [PAIR_W-1:0] rq_out_data;
  logic [PAIR_W-1:0] wq_in_data;
  logic [LVL_W-1:0]  wq_level;
  logic [WORD_W-1:0] rise_src;

  // Request fields are sampled in the cycle the grant is decided.
  assign new_cmd.addr = LINK.port_target_location;
  assign new_cmd.read = LINK.port_direction_is_read;
  assign new_cmd.len  = LINK.port_transfer_length_code;

  // Grants are limited so the two-entry queue can never overflow.
  assign outstanding = 3'(st_reg.rd_cnt) + 3'(st_reg.wr_cnt);
  // The cycle after a grant the request is still up by contract, so
  // it is ignored then rather than read as a second request.
  assign take = LINK.port_request && !st_reg.grant
             && (outstanding < OUTSTANDING_MAX);
  assign pop_cmd = MEM_CMD_READY && (st_reg.cmd_cnt != 2'h0);

  assign rq_fire    = MEM_RD_VALID && MEM_RD_READY;
  assign wq_fire    = MEM_WR_VALID && MEM_WR_READY;
  assign rd_ld_last = rq_fire && MEM_RD_LAST;
  assign wr_st_last = wq_fire && MEM_WR_LAST;

  // A rise word pushed alone waits for its fall partner; when both come
  // together the pair is built straight from the buses.
  assign rise_src   = LINK.write_push_rise ? LINK.write_bus_rise
                                           : st_reg.rise_hold;
  assign wq_in_data = {LINK.write_bus_fall, rise_src};

  always_comb
  begin
    st_next       = st_reg;
    st_next.grant = take;
    st_next.rdy   = 1'b0;
    // Head leaves first, so issue order equals grant order.
    if (pop_cmd)
    begin
      st_next.cmd0    = st_reg.cmd1;
      st_next.cmd_cnt = st_reg.cmd_cnt - 2'h1;
    end
    if (take)
    begin
      if (st_next.cmd_cnt == 2'h0)
      begin
        st_next.cmd0 = new_cmd;
      end
      else
      begin
        st_next.cmd1 = new_cmd;
      end
      st_next.cmd_cnt = st_next.cmd_cnt + 2'h1;
    end
    // Counting operations rather than flags keeps busy gapless.
    st_next.rd_cnt = st_reg.rd_cnt + 2'(take && new_cmd.read)
                   - 2'(rd_ld_last);
    st_next.wr_cnt = st_reg.wr_cnt + 2'(take && !new_cmd.read)
                   - 2'(wr_st_last);
    // First word of each read operation raises one ready pulse.
    if (rq_fire)
    begin
      st_next.rdy    = !st_reg.rd_mid;
      st_next.rd_mid = !MEM_RD_LAST;
    end
    // Indices advance per pop and restart when the operation closes;
    // bursts included, whose 16 pops step the indices across words 0 to 31.
    if (LINK.read_pop_rise)
    begin
      st_next.idx_rise = st_reg.idx_rise + IDX_STEP;
    end
    if (LINK.read_pop_fall)
    begin
      st_next.idx_fall = st_reg.idx_fall + IDX_STEP;
    end
    if (LINK.read_done_pulse || LINK.read_queue_flush)
    begin
      st_next.idx_rise = IDX_RISE_RST;
      st_next.idx_fall = IDX_FALL_RST;
    end
    if (LINK.write_push_rise)
    begin
      st_next.rise_hold = LINK.write_bus_rise;
    end
    if (LINK.write_queue_flush)
    begin
      st_next.rise_hold = '0;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      st_reg          <= '0;
      st_reg.idx_fall <= IDX_FALL_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Read queue: filled by the sequencer, drained by fall-phase pops.
  // Full read queue stalls the sequencer through its ready.
  mph_fifo #(
    .WIDTH (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_q (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .flush     (LINK.read_queue_flush),
    .in_valid  (MEM_RD_VALID),
    .in_ready  (MEM_RD_READY),
    .in_data   (MEM_RD_DATA),
    .out_valid (rq_out_valid),
    .out_ready (LINK.read_pop_fall),
    .out_data  (rq_out_data),
    .level     ()
  );

  // Write queue: a pair enters on each fall-phase push.
  mph_fifo #(
    .WIDTH (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_q (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .flush     (LINK.write_queue_flush),
    .in_valid  (LINK.write_push_fall),
    .in_ready  (wq_in_ready),
    .in_data   (wq_in_data),
    .out_valid (MEM_WR_VALID),
    .out_ready (MEM_WR_READY),
    .out_data  (MEM_WR_DATA),
    .level     (wq_level)
  );

  // Sequencer command outputs come from the queue head flops.
  assign MEM_CMD_VALID = st_reg.cmd_cnt != 2'h0;
  assign MEM_CMD_ADDR  = st_reg.cmd0.addr;
  assign MEM_CMD_READ  = st_reg.cmd0.read;
  assign MEM_CMD_LEN   = st_reg.cmd0.len;

  // Port outputs toward the peripheral.
  assign LINK.port_request_grant   = st_reg.grant;
  assign LINK.read_words_available = st_reg.rdy;
  assign LINK.read_bus_rise        = rq_out_data[WORD_W-1:0];
  assign LINK.read_bus_fall        = rq_out_data[PAIR_W-1:WORD_W];
  assign LINK.read_word_index_rise = st_reg.idx_rise;
  assign LINK.read_word_index_fall = st_reg.idx_fall;
  assign LINK.read_channel_active  = st_reg.rd_cnt != 2'h0;
  assign LINK.write_channel_active = st_reg.wr_cnt != 2'h0;
  // Warning one entry early leaves room for a push already decided.
  assign LINK.write_queue_full_rise = (wq_level >= WQ_WARN_LVL)
                                   || !wq_in_ready;
  assign LINK.write_queue_full_fall = (wq_level >= WQ_WARN_LVL)
                                   || !wq_in_ready;

endmodule

// ---- hdl/mph_per.sv ----
// Purpose: Peripheral end of one memory port, one operation at a time.
// Assumes: Read words for an operation arrive at least as fast as pops.
// Notes:   Pushes and their data are registered one cycle after decision.
`timescale 1ns/1ps
module mph_per
  import mph_pkg::*;
(
  // Clock and reset.
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  // Controller port.
  mph_link_if.per                LINK,
  // User commands.
  input  wire logic              USR_CMD_VALID,
  output logic                   USR_CMD_READY,
  input  wire logic [ADDR_W-1:0] USR_CMD_ADDR,
  input  wire logic              USR_CMD_READ,
  input  wire mph_len_t          USR_CMD_LEN,
  // User write data, one pair per beat.
  input  wire logic              USR_WR_VALID,
  output logic                   USR_WR_READY,
  input  wire logic [PAIR_W-1:0] USR_WR_DATA,
  // User read data and completion.
  output logic                   USR_RD_VALID,
  output logic [PAIR_W-1:0]      USR_RD_DATA,
  output logic                   USR_DONE
);

  typedef enum logic [2:0] {
    S_IDLE, S_REQ, S_RD_WAIT, S_RD_POP, S_WR_PUSH, S_WR_END
  } mph_per_state_t;

  typedef struct packed {
    mph_per_state_t    state;
    logic              req;
    mph_cmd_t          cmd;
    logic [4:0]        left;
    logic              push;
    logic [PAIR_W-1:0] wdata;
    logic              wdone;
    logic              rvalid;
    logic [PAIR_W-1:0] rdata;
    logic              done;
  } mph_per_st_t;

  mph_per_st_t st_reg;
  mph_per_st_t st_next;
  logic        pop;
  logic        wr_take;

  assign USR_CMD_READY = st_reg.state == S_IDLE;
  assign pop           = st_reg.state == S_RD_POP;
  // A push is decided only while no full warning stands.
  assign wr_take = (st_reg.state == S_WR_PUSH) && USR_WR_VALID
                && !LINK.write_queue_full_rise
                && !LINK.write_queue_full_fall;
  assign USR_WR_READY = wr_take;

  always_comb
  begin
    st_next        = st_reg;
    st_next.push   = wr_take;
    st_next.wdone  = 1'b0;
    st_next.rvalid = pop;
    st_next.done   = 1'b0;
    if (wr_take)
    begin
      st_next.wdata = USR_WR_DATA;
    end
    if (pop)
    begin
      st_next.rdata = {LINK.read_bus_fall, LINK.read_bus_rise};
    end
    unique case (st_reg.state)
      S_IDLE:
      begin
        if (USR_CMD_VALID)
        begin
          st_next.cmd.addr = USR_CMD_ADDR;
          st_next.cmd.read = USR_CMD_READ;
          st_next.cmd.len  = USR_CMD_LEN;
          st_next.left     = mph_pairs(USR_CMD_LEN);
          st_next.req      = 1'b1;
          st_next.state    = S_REQ;
        end
      end
      // Request and its fields stand until the grant is seen.
      S_REQ:
      begin
        if (LINK.port_request_grant)
        begin
          st_next.req   = 1'b0;
          st_next.state = st_reg.cmd.read ? S_RD_WAIT : S_WR_PUSH;
        end
      end
      S_RD_WAIT:
      begin
        if (LINK.read_words_available)
        begin
          st_next.state = S_RD_POP;
        end
      end
      S_RD_POP:
      begin
        st_next.left = st_reg.left - 5'h01;
        if (st_reg.left == 5'h01)
        begin
          st_next.done  = 1'b1;
          st_next.state = S_IDLE;
        end
      end
      S_WR_PUSH:
      begin
        if (wr_take)
        begin
          st_next.left = st_reg.left - 5'h01;
          if (st_reg.left == 5'h01)
          begin
            st_next.state = S_WR_END;
          end
        end
      end
      S_WR_END:
      begin
        st_next.wdone = 1'b1;
        st_next.done  = 1'b1;
        st_next.state = S_IDLE;
      end
      // Two of the eight state codes are unused; recover to idle.
      default:
      begin
        st_next.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Port drive; both phases pop and push together on a 64-bit peripheral.
  assign LINK.port_request              = st_reg.req;
  assign LINK.port_target_location      = st_reg.cmd.addr;
  assign LINK.port_direction_is_read    = st_reg.cmd.read;
  assign LINK.port_transfer_length_code = st_reg.cmd.len;
  assign LINK.read_pop_rise             = pop;
  assign LINK.read_pop_fall             = pop;
  assign LINK.read_done_pulse  = pop && (st_reg.left == 5'h01);
  assign LINK.read_queue_flush          = 1'b0;
  assign LINK.write_push_rise           = st_reg.push;
  assign LINK.write_push_fall           = st_reg.push;
  assign LINK.write_bus_rise            = st_reg.wdata[WORD_W-1:0];
  assign LINK.write_bus_fall            = st_reg.wdata[PAIR_W-1:WORD_W];
  assign LINK.write_done_pulse          = st_reg.wdone;
  assign LINK.write_queue_flush         = 1'b0;
  assign USR_RD_VALID                   = st_reg.rvalid;
  assign USR_RD_DATA                    = st_reg.rdata;
  assign USR_DONE                       = st_reg.done;

endmodule

// ---- sim/mph_link_checker.sv ----
// Purpose: Protocol checks on the link between both port ends.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Instantiated by the bench beside the link.
`timescale 1ns/1ps
module mph_link_checker
  import mph_pkg::*;
(
  // Clock and reset.
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  // Link signals.
  input wire logic       port_request,
  input wire logic       port_request_grant,
  input wire logic       port_direction_is_read,
  input wire logic       read_words_available,
  input wire logic       read_pop_rise,
  input wire logic       read_pop_fall,
  input wire logic       read_done_pulse,
  input wire logic [4:0] read_word_index_rise,
  input wire logic [4:0] read_word_index_fall,
  input wire logic       read_channel_active,
  input wire logic       write_push_fall,
  input wire logic       write_channel_active,
  input wire logic       write_queue_full_rise,
  input wire logic       write_queue_full_fall
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  // A request seen on one edge and granted on the next.
  sequence s_taken;
    port_request ##1 port_request_grant;
  endsequence

  grant_pulse_a:
    assert property (port_request_grant |=> !port_request_grant)
    else $error("grant too long");
  grant_cause_a:
    assert property ($rose(port_request_grant) |-> $past(port_request))
    else $error("grant without request");
  read_busy_a:
    assert property (s_taken ##0 port_direction_is_read
      |-> read_channel_active)
    else $error("read busy missing");
  write_busy_a:
    assert property (s_taken ##0 !port_direction_is_read
      |-> write_channel_active)
    else $error("write busy missing");
  ready_pulse_a:
    assert property (read_words_available |=> !read_words_available)
    else $error("ready too long");
  index_reset_a:
    assert property (read_done_pulse |=> read_word_index_rise == IDX_RISE_RST
      && read_word_index_fall == IDX_FALL_RST)
    else $error("index not reset");
  index_step_a:
    assert property (read_pop_rise && !read_done_pulse |=>
      read_word_index_rise == $past(read_word_index_rise) + IDX_STEP)
    else $error("index step wrong");
  index_fall_a:
    assert property (read_pop_fall && !read_done_pulse |=>
      read_word_index_fall == $past(read_word_index_fall) + IDX_STEP)
    else $error("fall index step wrong");
  full_cause_a:
    assert property ($rose(write_queue_full_rise) |->
      $past(write_push_fall) && write_queue_full_fall)
    else $error("full flags wrong");
endmodule

// ---- sim/mph_tb.sv ----
// Purpose: Joins both port ends; the bench acts as user and sequencer.
// Assumes: 10 MHz clock; the sequencer serves one command at a time.
// Notes:   One write run stalls the sequencer until the queue fills.
`timescale 1ns/1ps
module mph_tb
  import mph_pkg::*;
;
  logic              clk = 1'b0, rst_n = 1'b0, stall = 1'b0;
  logic              cv, cr = 1'b0, crd, rv = 1'b0, rr, rl = 1'b0;
  logic              wv, wr = 1'b0, wl = 1'b0, isrd, ucr, uwr, urv, ud;
  logic              uv = 1'b0, ur = 1'b0, uwv = 1'b0;
  logic [ADDR_W-1:0] ca, a, ua = '0;
  logic [PAIR_W-1:0] rd = '0, wd, uwd = '0, urd;
  mph_len_t          cl, ul = LEN_SINGLE;
  logic [PAIR_W-1:0] got[$];
  int                err_count = 0, samples_checked = 0, n;

  // Clock at 10 MHz.
  always #50 clk = ~clk;

  mph_link_if link ();
  mph_dev u_mph_dev (.REF_CLK(clk), .RST_N(rst_n), .LINK(link),
    .MEM_CMD_VALID(cv), .MEM_CMD_READY(cr), .MEM_CMD_ADDR(ca),
    .MEM_CMD_READ(crd), .MEM_CMD_LEN(cl), .MEM_RD_VALID(rv),
    .MEM_RD_READY(rr), .MEM_RD_DATA(rd), .MEM_RD_LAST(rl),
    .MEM_WR_VALID(wv), .MEM_WR_READY(wr), .MEM_WR_DATA(wd),
    .MEM_WR_LAST(wl));
  mph_per u_mph_per (.REF_CLK(clk), .RST_N(rst_n), .LINK(link),
    .USR_CMD_VALID(uv), .USR_CMD_READY(ucr), .USR_CMD_ADDR(ua),
    .USR_CMD_READ(ur), .USR_CMD_LEN(ul), .USR_WR_VALID(uwv),
    .USR_WR_READY(uwr), .USR_WR_DATA(uwd), .USR_RD_VALID(urv),
    .USR_RD_DATA(urd), .USR_DONE(ud));
  mph_link_checker u_mph_link_checker (.REF_CLK(clk), .RST_N(rst_n),
    .port_request(link.port_request),
    .port_request_grant(link.port_request_grant),
    .port_direction_is_read(link.port_direction_is_read),
    .read_words_available(link.read_words_available),
    .read_pop_rise(link.read_pop_rise),
    .read_pop_fall(link.read_pop_fall),
    .read_done_pulse(link.read_done_pulse),
    .read_word_index_rise(link.read_word_index_rise),
    .read_word_index_fall(link.read_word_index_fall),
    .read_channel_active(link.read_channel_active),
    .write_push_fall(link.write_push_fall),
    .write_channel_active(link.write_channel_active),
    .write_queue_full_rise(link.write_queue_full_rise),
    .write_queue_full_fall(link.write_queue_full_fall));

  // Pairs per operation: words of the length code, two words a pair.
  function automatic int npairs(input mph_len_t l);
    return (l == LEN_BURST32) ? 16 : 1 << int'(l);
  endfunction

  // Word pattern derived from the address, so order errors show.
  function automatic logic [PAIR_W-1:0] pat(input logic [31:0] b, input int i);
    return {b + 32'(2 * i + 1), b + 32'(2 * i)};
  endfunction

  task automatic check(input string what, input logic [PAIR_W-1:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Sequencer stand-in; the stall flag holds back write draining.
  initial
  begin
    forever
    begin
      @(negedge clk);
      if (cv === 1'b1)
      begin
        n = npairs(cl);
        a = ca;
        isrd = crd;
        cr = 1'b1;
        @(negedge clk);
        cr = 1'b0;
        for (int i = 0; i < n; i++)
          if (isrd)
          begin
            rv = 1'b1;
            rd = pat(a, i);
            rl = (i == n - 1);
            while (rr !== 1'b1)
              @(negedge clk);
            @(negedge clk);
          end
          else
          begin
            while (wv !== 1'b1 || stall)
            begin
              wr = 1'b0;
              @(negedge clk);
            end
            wr = 1'b1;
            wl = (i == n - 1);
            got.push_back(wd);
            @(negedge clk);
          end
        {rv, rl, wr, wl} = 4'h0;
      end
    end
  end

  task automatic issue(input logic [31:0] b, input logic r, input mph_len_t l);
    @(negedge clk);
    uv = 1'b1;
    ua = b;
    ur = r;
    ul = l;
    for (int k = 0; k < 200 && ucr !== 1'b1; k++)
      @(negedge clk);
    @(negedge clk);
    uv = 1'b0;
  endtask

  // A read of one length must return every pair in ascending order.
  task automatic t_read(input mph_len_t l);
    int m;
    m = 0;
    issue(32'h400 * (32'(l) + 32'h1), DIR_READ, l);
    for (int k = 0; k < 300 && ud !== 1'b1; k++)
    begin
      @(negedge clk);
      if (urv === 1'b1)
      begin
        check("read pair", urd, pat(ua, m));
        m++;
      end
    end
    check("read pairs", 64'(m), 64'(npairs(l)));
    check("read busy", 64'(link.read_channel_active), 64'h0);
    $display("read length %0d done", l);
  endtask

  // Writes; with hold set, memory stalls until the queue reports full.
  task automatic t_write(input mph_len_t l, input int ops, input logic hold);
    int m;
    m = npairs(l);
    got.delete();
    stall = hold;
    if (hold)
      fork
        begin
          for (int j = 0; j < 400 && link.write_queue_full_rise !== 1'b1; j++)
            @(negedge clk);
          check("full", 64'(link.write_queue_full_fall), 64'h1);
          check("busy", 64'(link.write_channel_active), 64'h1);
          stall = 1'b0;
        end
      join_none
    for (int op = 0; op < ops; op++)
    begin
      issue(32'h8000 + 32'(op) * 32'h80, DIR_WRITE, l);
      for (int i = 0; i < m; i++)
      begin
        uwv = 1'b1;
        uwd = pat(32'h0, op * m + i);
        for (int k = 0; k < 400 && uwr !== 1'b1; k++)
          @(negedge clk);
        @(negedge clk);
      end
      uwv = 1'b0;
      for (int k = 0; k < 300 && ud !== 1'b1; k++)
        @(negedge clk);
      check("write done", 64'(ud), 64'h1);
    end
    for (int k = 0; k < 300 && link.write_channel_active !== 1'b0; k++)
      @(negedge clk);
    check("write pairs", 64'(got.size()), 64'(ops * m));
    check("write addr", 64'(a), 64'(32'h8000 + 32'(ops - 1) * 32'h80));
    foreach (got[i])
      check("write pair", got[i], pat(32'h0, i));
    $display("write length %0d x%0d done", l, ops);
  endtask

  // Main sequence: reset for five cycles, then every length each way.
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int l = 0; l < 4; l++)
      t_read(mph_len_t'(l));
    for (int l = 0; l < 4; l++)
      t_write(mph_len_t'(l), 1, 1'b0);
    t_write(LEN_BURST32, 2, 1'b1);
    tally_and_finish();
  end

  // Watchdog: the tests need well under 20000 cycles.
  initial
  begin
    #2000000;
    err_count++;
    tally_and_finish();
  end
endmodule
